// >>> cell_protect_seq.sv
// Fault sequencer for a one-cell battery protector: qualifies comparator results,
// drives the charge and discharge gate outputs and latches faults until release.
// Assumes all comparator inputs are already synchronous to i_ref_clk.
//
// Operation
// - Over-charge or charge over-current drops charge gate
// - Over-discharge or discharge over-current drops discharge gate
// - Over-charge qualified for one second
// - Detect delays 20 ms (fast mode shortens), fixed 12 ms, 16 ms
// - Short circuit qualified for 250 us
// - Charge fault clears: charger gone, cell low
// - Charger present keeps over-charge latched
// - Over-discharge clears: charger present, voltage recovered
// - Current or short fault clears on load removal
// - Over-discharge latched enters low-current standby
// - Fast mode divides over-charge and over-discharge detect delays by hundred
// - Over-charge and over-discharge latch until release
// - Zero-volt cell blocks recharge
// - Over-charge release qualified for 16 ms
// - Over-discharge release qualified for 1.2 ms
`timescale 1ns/10ps
module cell_protect_seq
  import cell_protect_pkg::*;
#(
  parameter int unsigned CNT_W       = CNT_W_DEF,
  parameter int unsigned P_OVC_DET   = OVC_DET_CYC,
  parameter int unsigned P_OVD_DET   = OVD_DET_CYC,
  parameter int unsigned P_EDC_DET   = EDC_DET_CYC,
  parameter int unsigned P_ECC_DET   = ECC_DET_CYC,
  parameter int unsigned P_CHG_REL   = CHG_REL_CYC,
  parameter int unsigned P_DIS_REL   = DIS_REL_CYC
) (
  input  wire logic i_ref_clk,
  input  wire logic i_rst_b,
  input  wire logic i_ce,
  input  wire logic i_over_chg,
  input  wire logic i_under_dis,
  input  wire logic i_dis_ovcur,
  input  wire logic i_chg_ovcur,
  input  wire logic i_short,
  input  wire logic i_charger,
  input  wire logic i_load,
  input  wire logic i_zero_volt,
  input  wire logic i_fast_range,
  output logic      o_chg_gate,
  output logic      o_dis_gate,
  output logic      o_standby,
  output logic      o_fast_mode,
  output logic      o_ovc_latched,
  output logic      o_ecc_latched,
  output logic      o_ovd_latched,
  output logic      o_edc_latched,
  output logic      o_sc_latched
);

  // ----------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------
  initial begin
    if (CNT_W < 2 || CNT_W > 31) $error("cell_protect_seq: CNT_W out of range");
    if (P_OVC_DET < FAST_DIV || P_OVD_DET < FAST_DIV) $error("cell_protect_seq: detect count too small");
    if (P_EDC_DET < 1 || P_ECC_DET < 1 || P_CHG_REL < 1 || P_DIS_REL < 1)
      $error("cell_protect_seq: count must be at least one");
    if (P_OVC_DET >= (1 << CNT_W) || P_OVD_DET >= (1 << CNT_W) || P_EDC_DET >= (1 << CNT_W) ||
        P_ECC_DET >= (1 << CNT_W) || P_CHG_REL >= (1 << CNT_W) || P_DIS_REL >= (1 << CNT_W) ||
        SC_DET_CYC >= (1 << CNT_W))
      $error("cell_protect_seq: count does not fit CNT_W");
  end

  function automatic logic [CNT_W-1:0] to_cnt(input int unsigned cyc);
    to_cnt = CNT_W'(cyc);
  endfunction

  // ----------------------------------------------------------------
  // Latched fault state
  // ----------------------------------------------------------------
  logic ovc_reg;
  logic ovc_next;
  logic ecc_reg;
  logic ecc_next;
  logic ovd_reg;
  logic ovd_next;
  logic edc_reg;
  logic edc_next;
  logic sc_reg;
  logic sc_next;
  logic chg_gate_reg;
  logic chg_gate_next;
  logic dis_gate_reg;
  logic dis_gate_next;

  logic [Q_NUM-1:0]  q_cond;
  logic [Q_NUM-1:0]  q_done;
  logic [CNT_W-1:0]  q_limit [Q_NUM];

  logic chg_fault;
  logic cur_fault;
  logic fast_mode;
  logic run;

  assign chg_fault = ovc_reg | ecc_reg;
  assign cur_fault = edc_reg | sc_reg;

  // Shortening is only honoured while the charge gate is on
  assign fast_mode = chg_gate_reg & i_fast_range;

  // Standby halts every detector; all three release qualifiers keep running
  assign run = ~ovd_reg;

  // ----------------------------------------------------------------
  // Qualifier conditions and limits
  // ----------------------------------------------------------------
  always_comb begin
    q_cond[Q_OVC_DET] = run & ~chg_fault & i_over_chg;
    q_cond[Q_ECC_DET] = run & ~chg_fault & i_chg_ovcur;
    q_cond[Q_OVD_DET] = run & ~cur_fault & i_under_dis;
    q_cond[Q_EDC_DET] = run & ~cur_fault & i_dis_ovcur;
    q_cond[Q_SC_DET]  = run & ~cur_fault & i_short;
    q_cond[Q_CHG_REL] = chg_fault & ~i_charger & ~i_over_chg;
    q_cond[Q_OVD_REL] = ovd_reg & i_charger & ~i_under_dis;
    q_cond[Q_CUR_REL] = cur_fault & ~i_load;
  end

  always_comb begin
    q_limit[Q_OVC_DET] = fast_mode ? to_cnt(P_OVC_DET / FAST_DIV) : to_cnt(P_OVC_DET);
    q_limit[Q_OVD_DET] = fast_mode ? to_cnt(P_OVD_DET / FAST_DIV) : to_cnt(P_OVD_DET);
    q_limit[Q_ECC_DET] = to_cnt(P_ECC_DET);
    q_limit[Q_EDC_DET] = to_cnt(P_EDC_DET);
    q_limit[Q_SC_DET]  = to_cnt(SC_DET_CYC);
    q_limit[Q_CHG_REL] = to_cnt(P_CHG_REL);
    q_limit[Q_OVD_REL] = to_cnt(P_DIS_REL);
    q_limit[Q_CUR_REL] = to_cnt(P_DIS_REL);
  end

  // ----------------------------------------------------------------
  // One counter per qualifier, all on the reference clock
  // ----------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < Q_NUM; gi++) begin : g_qual
      delay_qualifier #(
        .CNT_W (CNT_W)
      ) u_qual (
        .i_ref_clk (i_ref_clk),
        .i_rst_b   (i_rst_b),
        .i_ce      (i_ce),
        .i_cond    (q_cond[gi]),
        .i_limit   (q_limit[gi]),
        .o_done    (q_done[gi])
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // Fault latches and gate drive
  // ----------------------------------------------------------------
  always_comb begin
    ovc_next = ovc_reg;
    ecc_next = ecc_reg;
    ovd_next = ovd_reg;
    edc_next = edc_reg;
    sc_next  = sc_reg;
    // Release first, detection after, so a fresh fault wins the same cycle.
    // A release also needs its condition in this cycle: a charger or load
    // that returns on the last cycle still blocks it.
    if (q_done[Q_CHG_REL] && q_cond[Q_CHG_REL]) begin
      ovc_next = 1'b0;
      ecc_next = 1'b0;
    end
    if (q_done[Q_OVD_REL] && q_cond[Q_OVD_REL]) begin
      ovd_next = 1'b0;
    end
    if (q_done[Q_CUR_REL] && q_cond[Q_CUR_REL]) begin
      edc_next = 1'b0;
      sc_next  = 1'b0;
    end
    if (q_done[Q_OVC_DET]) begin
      ovc_next = 1'b1;
    end
    if (q_done[Q_ECC_DET]) begin
      ecc_next = 1'b1;
    end
    if (q_done[Q_OVD_DET]) begin
      ovd_next = 1'b1;
    end
    if (q_done[Q_EDC_DET]) begin
      edc_next = 1'b1;
    end
    if (q_done[Q_SC_DET]) begin
      sc_next = 1'b1;
    end
    // A dead cell is never offered charge current
    chg_gate_next = ~(ovc_next | ecc_next) & ~i_zero_volt;
    dis_gate_next = ~(ovd_next | edc_next | sc_next);
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      ovc_reg      <= 1'b0;
      ecc_reg      <= 1'b0;
      ovd_reg      <= 1'b0;
      edc_reg      <= 1'b0;
      sc_reg       <= 1'b0;
      chg_gate_reg <= 1'b0;
      dis_gate_reg <= 1'b0;
    end else if (i_ce) begin
      ovc_reg      <= ovc_next;
      ecc_reg      <= ecc_next;
      ovd_reg      <= ovd_next;
      edc_reg      <= edc_next;
      sc_reg       <= sc_next;
      chg_gate_reg <= chg_gate_next;
      dis_gate_reg <= dis_gate_next;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign o_chg_gate    = chg_gate_reg;
  assign o_dis_gate    = dis_gate_reg;
  assign o_standby     = ovd_reg;
  assign o_fast_mode   = fast_mode;
  assign o_ovc_latched = ovc_reg;
  assign o_ecc_latched = ecc_reg;
  assign o_ovd_latched = ovd_reg;
  assign o_edc_latched = edc_reg;
  assign o_sc_latched  = sc_reg;

endmodule // cell_protect_seq

// >>> cell_protect_pkg.sv
// Constants shared by the cell protection fault sequencer and its delay qualifiers.
// Assumes one reference clock at the rate given by CLK_PERIOD_NS.
package cell_protect_pkg;

  // ----------------------------------------------------------------
  // Clock
  // ----------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS = 100;

  // ----------------------------------------------------------------
  // Qualification times in their own units
  // ----------------------------------------------------------------
  localparam int unsigned T_OVC_DET_MS  = 1000;  // 1.0 s
  localparam int unsigned T_OVD_DET_MS  = 20;
  localparam int unsigned T_EDC_DET_MS  = 12;
  localparam int unsigned T_ECC_DET_MS  = 16;
  localparam int unsigned T_SC_DET_US   = 250;
  localparam int unsigned T_CHG_REL_MS  = 16;
  localparam int unsigned T_DIS_REL_US  = 1200;  // 1.2 ms
  localparam int unsigned FAST_DIV      = 100;

  // ----------------------------------------------------------------
  // Derived cycle counts, exact at 100 ns
  // ----------------------------------------------------------------
  localparam int unsigned OVC_DET_CYC = T_OVC_DET_MS * 1_000_000 / CLK_PERIOD_NS;
  localparam int unsigned OVD_DET_CYC = T_OVD_DET_MS * 1_000_000 / CLK_PERIOD_NS;
  localparam int unsigned EDC_DET_CYC = T_EDC_DET_MS * 1_000_000 / CLK_PERIOD_NS;
  localparam int unsigned ECC_DET_CYC = T_ECC_DET_MS * 1_000_000 / CLK_PERIOD_NS;
  localparam int unsigned SC_DET_CYC  = T_SC_DET_US * 1_000 / CLK_PERIOD_NS;
  localparam int unsigned CHG_REL_CYC = T_CHG_REL_MS * 1_000_000 / CLK_PERIOD_NS;
  localparam int unsigned DIS_REL_CYC = T_DIS_REL_US * 1_000 / CLK_PERIOD_NS;

  // ----------------------------------------------------------------
  // Qualifier slots
  // ----------------------------------------------------------------
  localparam int unsigned Q_OVC_DET = 0;
  localparam int unsigned Q_ECC_DET = 1;
  localparam int unsigned Q_OVD_DET = 2;
  localparam int unsigned Q_EDC_DET = 3;
  localparam int unsigned Q_SC_DET  = 4;
  localparam int unsigned Q_CHG_REL = 5;
  localparam int unsigned Q_OVD_REL = 6;
  localparam int unsigned Q_CUR_REL = 7;
  localparam int unsigned Q_NUM     = 8;

  localparam int unsigned CNT_W_DEF = 24;

endpackage

// >>> delay_qualifier.sv
// Persistence qualifier: a condition must hold for i_limit consecutive enabled cycles.
// Assumes i_limit is at least one and stays steady while the condition holds.
`timescale 1ns/10ps
module delay_qualifier #(
  parameter int unsigned CNT_W = 24
) (
  input  wire logic             i_ref_clk,
  input  wire logic             i_rst_b,
  input  wire logic             i_ce,
  input  wire logic             i_cond,
  input  wire logic [CNT_W-1:0] i_limit,
  output logic                  o_done
);

  logic [CNT_W-1:0] cnt_reg;
  logic [CNT_W-1:0] cnt_next;
  logic             done_reg;
  logic             done_next;

  initial begin
    if (CNT_W < 2 || CNT_W > 31) $error("delay_qualifier: CNT_W out of range");
  end

  // ----------------------------------------------------------------
  // Counter
  // ----------------------------------------------------------------
  always_comb begin
    cnt_next  = cnt_reg;
    done_next = done_reg;
    if (!i_cond) begin
      // A condition that drops early starts the wait over
      cnt_next  = '0;
      done_next = 1'b0;
    end else if (!done_reg) begin
      if (cnt_reg >= i_limit - CNT_W'(1)) begin
        done_next = 1'b1;
      end else begin
        cnt_next = cnt_reg + CNT_W'(1);
      end
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      cnt_reg  <= '0;
      done_reg <= 1'b0;
    end else if (i_ce) begin
      cnt_reg  <= cnt_next;
      done_reg <= done_next;
    end
  end

  assign o_done = done_reg;

endmodule // delay_qualifier

// >>> cell_protect_seq_asserts.sv
// Port checker for the cell protection fault sequencer.
// Assumes one clock domain; attached by bind to every sequencer instance.
`timescale 1ns/10ps
module cell_protect_seq_chk
  import cell_protect_pkg::*;
(
  input wire logic i_ref_clk,
  input wire logic i_rst_b,
  input wire logic i_ce,
  input wire logic i_over_chg,
  input wire logic i_under_dis,
  input wire logic i_short,
  input wire logic i_charger,
  input wire logic i_load,
  input wire logic i_zero_volt,
  input wire logic i_fast_range,
  input wire logic o_chg_gate,
  input wire logic o_dis_gate,
  input wire logic o_standby,
  input wire logic o_fast_mode,
  input wire logic o_ovc_latched,
  input wire logic o_ecc_latched,
  input wire logic o_ovd_latched,
  input wire logic o_edc_latched,
  input wire logic o_sc_latched
);
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_b);

  // Run length of the short input; a latch before 2500 means a missed restart
  logic [15:0] sc_run;
  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) sc_run <= 16'h0000;
    else if (i_ce) sc_run <= i_short ? sc_run + 16'h0001 : 16'h0000;
  end

  sequence s_ovd_fault;
    $rose(o_ovd_latched);
  endsequence
  sequence s_halt;
    o_standby && !o_dis_gate;
  endsequence

  AST_CHG_CAUSE: assert property ($fell(o_chg_gate) |->
    o_ovc_latched || o_ecc_latched || $past(i_zero_volt)) else $error("charge gate fell without cause");
  AST_DIS_CAUSE: assert property ($fell(o_dis_gate) |->
    o_ovd_latched || o_edc_latched || o_sc_latched) else $error("discharge gate fell without cause");
  AST_SC_TIME: assert property ($rose(o_sc_latched) |-> $past(sc_run) >= SC_DET_CYC)
    else $error("short latched too early");
  AST_CHG_KEEP: assert property (o_ovc_latched && i_charger |=> o_ovc_latched)
    else $error("over-charge released with charger present");
  AST_OVD_HALT: assert property (s_ovd_fault |-> ##[0:1] s_halt)
    else $error("no standby after over-discharge");
  AST_STBY_ONLY: assert property (o_standby |-> o_ovd_latched)
    else $error("standby without over-discharge");
  // Two enabled cycles into standby no detector may still be counting
  AST_STBY_HALT: assert property (o_standby && $past(o_standby, 2) && $past(i_ce, 2) |->
    !$rose(o_ovc_latched) && !$rose(o_ecc_latched) && !$rose(o_edc_latched) && !$rose(o_sc_latched))
    else $error("detector latched during standby");
  AST_OVD_REL: assert property ($fell(o_ovd_latched) |-> $past(i_charger && !i_under_dis))
    else $error("over-discharge released without cause");
  AST_CUR_REL: assert property ($fell(o_edc_latched) || $fell(o_sc_latched) |-> $past(!i_load))
    else $error("current fault released with load");
  AST_CHG_REL: assert property ($fell(o_ovc_latched) |-> $past(!i_charger && !i_over_chg))
    else $error("over-charge released without cause");
  AST_FAST: assert property (o_fast_mode == (o_chg_gate && i_fast_range))
    else $error("fast mode flag wrong");
  AST_ZERO: assert property ($past(i_zero_volt && i_ce) |-> !o_chg_gate)
    else $error("charge gate on with zero-volt cell");
endmodule // cell_protect_seq_chk

bind cell_protect_seq cell_protect_seq_chk i_chk (.i_ref_clk, .i_rst_b, .i_ce, .i_over_chg, .i_under_dis,
  .i_short, .i_charger, .i_load, .i_zero_volt, .i_fast_range, .o_chg_gate, .o_dis_gate, .o_standby,
  .o_fast_mode, .o_ovc_latched, .o_ecc_latched, .o_ovd_latched, .o_edc_latched, .o_sc_latched);

// >>> pack_side_model.sv
// Far side of the pack: charger, load and the two series gate switches.
// Assumes a gate output high means its switch conducts.
`timescale 1ns/10ps
module pack_side_model (
  input  wire logic i_plug,
  input  wire logic i_attach,
  input  wire logic i_chg_gate,
  input  wire logic i_dis_gate,
  output logic      o_charger,
  output logic      o_load,
  output logic      o_chg_flow
);
  assign o_charger  = i_plug;
  assign o_load     = i_attach;
  // Charge current needs both series switches on
  assign o_chg_flow = i_plug && i_chg_gate && i_dis_gate;
endmodule // pack_side_model

// >>> tb.sv
// Self-checking bench for the cell protection fault sequencer.
// Assumes shortened detect counts; the short delay keeps its package value.
`timescale 1ns/10ps
module tb;
  import cell_protect_pkg::*;
  localparam int OVC_N = 1000;
  localparam int OVD_N = 200;
  localparam int EDC_N = 30;
  localparam int ECC_N = 40;
  localparam int REL_N = 40;
  localparam int DREL_N = 12;
  logic i_ref_clk, i_rst_b, i_ce, i_over_chg, i_under_dis, i_dis_ovcur, i_chg_ovcur;
  logic i_short, i_zero_volt, i_fast_range, plug, attach, i_charger, i_load, chg_flow;
  logic o_chg_gate, o_dis_gate, o_standby, o_fast_mode;
  logic o_ovc_latched, o_ecc_latched, o_ovd_latched, o_edc_latched, o_sc_latched;
  int   error_cnt, num_checks, cyc;

  cell_protect_seq #(.P_OVC_DET(OVC_N), .P_OVD_DET(OVD_N), .P_EDC_DET(EDC_N), .P_ECC_DET(ECC_N),
    .P_CHG_REL(REL_N), .P_DIS_REL(DREL_N)) i_dut (.i_ref_clk, .i_rst_b, .i_ce, .i_over_chg,
    .i_under_dis, .i_dis_ovcur, .i_chg_ovcur, .i_short, .i_charger, .i_load, .i_zero_volt,
    .i_fast_range, .o_chg_gate, .o_dis_gate, .o_standby, .o_fast_mode, .o_ovc_latched,
    .o_ecc_latched, .o_ovd_latched, .o_edc_latched, .o_sc_latched);
  pack_side_model i_pack (.i_plug(plug), .i_attach(attach), .i_chg_gate(o_chg_gate),
    .i_dis_gate(o_dis_gate), .o_charger(i_charger), .o_load(i_load), .o_chg_flow(chg_flow));

  initial begin
    i_ref_clk = 1'b0;
    forever #50 i_ref_clk = ~i_ref_clk;
  end

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic check(input logic seen, input logic exp);
    num_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge i_ref_clk);
  endtask
  // Change lands N+1 edges after the driving edge: unchanged at N, changed by N+3
  task automatic gate_step(input int n, input bit dis, input logic v0);
    tick(n);
    #1 check(dis ? o_dis_gate : o_chg_gate, v0);
    tick(3);
    #1 check(dis ? o_dis_gate : o_chg_gate, ~v0);
  endtask
  task automatic report_and_stop;
    $display("checks=%0d errors=%0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  always @(posedge i_ref_clk) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      report_and_stop();
    end
  end

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_ovc;
    @(posedge i_ref_clk);
    plug <= 1'b1;
    i_over_chg <= 1'b1;
    gate_step(OVC_N, 0, 1'b1);
    check(o_ovc_latched, 1'b1);
    @(posedge i_ref_clk);
    i_over_chg <= 1'b0;
    tick(100);
    #1 check(o_chg_gate, 1'b0);
    @(posedge i_ref_clk);
    plug <= 1'b0;
    gate_step(REL_N, 0, 1'b0);
    $display("over-charge test done");
  endtask
  task automatic t_fast;
    @(posedge i_ref_clk);
    i_fast_range <= 1'b1;
    tick(1);
    #1 check(o_fast_mode, 1'b1);
    @(posedge i_ref_clk);
    i_over_chg <= 1'b1;
    gate_step(OVC_N / FAST_DIV, 0, 1'b1);
    check(o_fast_mode, 1'b0);
    @(posedge i_ref_clk);
    i_over_chg <= 1'b0;
    i_fast_range <= 1'b0;
    gate_step(REL_N, 0, 1'b0);
    $display("fast mode test done");
  endtask
  task automatic t_ecc;
    @(posedge i_ref_clk);
    plug <= 1'b1;
    i_chg_ovcur <= 1'b1;
    gate_step(ECC_N, 0, 1'b1);
    check(o_ecc_latched, 1'b1);
    @(posedge i_ref_clk);
    plug <= 1'b0;
    i_chg_ovcur <= 1'b0;
    gate_step(REL_N, 0, 1'b0);
    $display("charge current test done");
  endtask
  task automatic t_ovd;
    @(posedge i_ref_clk);
    i_under_dis <= 1'b1;
    gate_step(OVD_N, 1, 1'b1);
    check(o_standby, 1'b1);
    check(o_ovd_latched, 1'b1);
    @(posedge i_ref_clk);
    plug <= 1'b1;
    i_under_dis <= 1'b0;
    gate_step(DREL_N, 1, 1'b0);
    check(o_standby, 1'b0);
    @(posedge i_ref_clk);
    plug <= 1'b0;
    $display("over-discharge test done");
  endtask
  task automatic t_edc;
    @(posedge i_ref_clk);
    i_dis_ovcur <= 1'b1;
    gate_step(EDC_N, 1, 1'b1);
    @(posedge i_ref_clk);
    i_dis_ovcur <= 1'b0;
    tick(50);
    #1 check(o_edc_latched, 1'b1);
    @(posedge i_ref_clk);
    attach <= 1'b0;
    gate_step(DREL_N, 1, 1'b0);
    @(posedge i_ref_clk);
    attach <= 1'b1;
    $display("discharge current test done");
  endtask
  task automatic t_sc;
    @(posedge i_ref_clk);
    i_short <= 1'b1;
    tick(2000);
    i_short <= 1'b0;
    @(posedge i_ref_clk);
    i_short <= 1'b1;
    gate_step(SC_DET_CYC, 1, 1'b1);
    check(o_sc_latched, 1'b1);
    @(posedge i_ref_clk);
    i_short <= 1'b0;
    attach <= 1'b0;
    gate_step(DREL_N, 1, 1'b0);
    @(posedge i_ref_clk);
    attach <= 1'b1;
    $display("short test done");
  endtask
  // Nothing may count while the clock enable is low
  task automatic t_freeze;
    @(posedge i_ref_clk);
    i_ce <= 1'b0;
    i_dis_ovcur <= 1'b1;
    tick(EDC_N + 5);
    #1 check(o_dis_gate, 1'b1);
    @(posedge i_ref_clk);
    i_ce <= 1'b1;
    gate_step(EDC_N, 1, 1'b1);
    @(posedge i_ref_clk);
    i_dis_ovcur <= 1'b0;
    attach <= 1'b0;
    gate_step(DREL_N, 1, 1'b0);
    @(posedge i_ref_clk);
    attach <= 1'b1;
    $display("clock enable test done");
  endtask
  task automatic t_zero;
    @(posedge i_ref_clk);
    plug <= 1'b1;
    i_zero_volt <= 1'b1;
    gate_step(0, 0, 1'b1);
    check(chg_flow, 1'b0);
    @(posedge i_ref_clk);
    i_zero_volt <= 1'b0;
    gate_step(0, 0, 1'b0);
    $display("zero-volt test done");
  endtask

  initial begin
    {i_rst_b, i_over_chg, i_under_dis, i_dis_ovcur, i_chg_ovcur} = 5'h00;
    {i_short, i_zero_volt, i_fast_range, plug} = 4'h0;
    i_ce = 1'b1;
    attach = 1'b1;
    error_cnt = 0;
    num_checks = 0;
    cyc = 0;
    tick(20);
    i_rst_b <= 1'b1;
    tick(2);
    #1 check(o_chg_gate, 1'b1);
    check(o_dis_gate, 1'b1);
    t_ovc();
    t_fast();
    t_ecc();
    t_ovd();
    t_edc();
    t_freeze();
    t_sc();
    t_zero();
    report_and_stop();
  end
endmodule // tb
